/* pkg/tuc_params.svh */
/*
 * Offsets, field positions and reset values of the timer
 * update-control register slice.
 * Assumes word-aligned AHB-Lite access: byte address = 4 * register index.
 */
`ifndef TUC_PARAMS_SVH
`define TUC_PARAMS_SVH

// Register indices (byte address is four times the index)
`define TUC_IDX_ENABLE_CTRL      8'h00
`define TUC_IDX_MODE_CTRL        8'h01
`define TUC_IDX_OUTPUT_VALUE     8'h02
`define TUC_IDX_SPLIT_MODE       8'h03
`define TUC_IDX_UPD_DIR_CLR      8'h04
`define TUC_IDX_UPD_DIR_SET      8'h05
`define TUC_IDX_BUF_VALID_CLR    8'h06
`define TUC_IDX_BUF_VALID_SET    8'h07
`define TUC_IDX_ACTIVE_PERIOD    8'h26
`define TUC_IDX_ACTIVE_CMP0      8'h28
`define TUC_IDX_ACTIVE_CMP1      8'h2A
`define TUC_IDX_ACTIVE_CMP2      8'h2C
`define TUC_IDX_PERIOD_BUF       8'h36
`define TUC_IDX_CMP0_BUF         8'h38
`define TUC_IDX_CMP1_BUF         8'h3A
`define TUC_IDX_CMP2_BUF         8'h3C

// Field positions
`define TUC_BIT_ENABLE           0
`define TUC_BIT_SPLIT            0
`define TUC_BIT_DIR              0
`define TUC_BIT_LOCK             1
`define TUC_POS_CMD_LO           2
`define TUC_POS_CMD_HI           3
`define TUC_BIT_AUTO_LOCK        3
`define TUC_POS_WGMODE_HI        2
`define TUC_POS_CMPEN_LO         4
`define TUC_POS_CMPEN_HI         6

// Reset values
`define TUC_RST_CTRL             8'h00
`define TUC_RST_PERIOD           16'hFFFF
`define TUC_RST_CMP              16'h0000

`endif

/* pkg/tuc_pkg.sv */
/*
 * Types of the timer update-control register slice.
 * Assumes tuc_params.svh supplies the numeric constants.
 */
package tuc_pkg;

    typedef enum logic [1:0] {
        TUC_CMD_NONE    = 2'h0,
        TUC_CMD_UPDATE  = 2'h1,
        TUC_CMD_RESTART = 2'h2,
        TUC_CMD_RESET   = 2'h3
    } tuc_cmd_t;

    typedef enum logic [2:0] {
        TUC_ST_IDLE = 3'h0,
        TUC_ST_WR   = 3'h1,
        TUC_ST_RD1  = 3'h2,
        TUC_ST_RD2  = 3'h3,
        TUC_ST_RDY  = 3'h4
    } tuc_state_t;

endpackage : tuc_pkg

/* rtl/tuc_buf_mem.sv */
/*
 * Buffer store for the period and compare buffer words.
 * Assumes one write and one read per cycle; read data is registered, and the
 * whole content is also visible for the parallel copy on UPDATE.
 */
`timescale 1ns/1ps
`include "tuc_params.svh"

module tuc_buf_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata,
    output logic [DEPTH*WIDTH-1:0] all_q
);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [WIDTH-1:0] rdata_next;

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (we) begin
            mem_next[waddr] = wdata;
        end
        rdata_next = mem_reg[raddr];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            rdata <= '0;
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= mem_next[i];
            end
            rdata <= rdata_next;
        end
    end

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            all_q[i*WIDTH +: WIDTH] = mem_reg[i];
        end
    end

endmodule : tuc_buf_mem

/* rtl/tuc_regs.sv */
/*
 * Control and status register slice of a 16-bit timer: output override,
 * split mode, command/lock/direction set-clear pair, buffer-valid set-clear
 * pair, buffered period/compare words and their active copies.
 * Assumes an AHB-Lite master with this module as the only slave, and a timer
 * core on the same clock giving UPDATE and direction pulses.
 */
`timescale 1ns/1ps
`include "tuc_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Disabled timer: override bits drive waveform outputs
// - Split bit selects two 8-bit counters
// - Clear register: ones clear, zeros keep
// - Set register: ones set, zeros keep
// - Set and clear addresses read same bits
// - Command field: update, restart, reset-if-disabled
// - Command field always reads zero
// - Lock blocks buffer loads on UPDATE
// - Direction bit: zero up, one down
// - Hardware and software both steer direction
// - Compare buffer write sets its valid flag
// - Period buffer write sets its valid flag
// - Unlocked UPDATE clears all buffer valid flags except one written that cycle
// - Unlocked UPDATE copies valid buffers to active
// - Auto-lock holds lock until enabled buffers valid
module tuc_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic update_event,
    input wire logic hw_dir_up,
    input wire logic hw_dir_down,
    output logic timer_enable,
    output logic [2:0] wgmode,
    output logic [2:0] compare_enable,
    output logic split_mode_enable,
    output logic count_down,
    output logic [2:0] wg_out,
    output logic wg_out_forced,
    output logic update_pulse,
    output logic restart_pulse,
    output logic hard_reset_pulse,
    output logic [15:0] active_period,
    output logic [47:0] active_compare
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    tuc_pkg::tuc_state_t state_reg, state_next;
    logic [7:0] idx_reg, idx_next;
    logic [31:0] hrdata_next;
    logic hreadyout_next;
    logic enable_reg, enable_next;
    logic [6:0] mode_reg, mode_next;
    logic [2:0] cov_reg, cov_next;
    logic split_reg, split_next;
    logic lock_reg, lock_next;
    logic dir_reg, dir_next;
    logic [3:0] bv_reg, bv_next;
    logic upd_reg, upd_next;
    logic rst_reg, rst_next;
    logic hrst_reg, hrst_next;
    logic [2:0] wg_reg, wg_next;
    logic forced_reg, forced_next;
    logic [15:0] act_reg [4];
    logic [15:0] act_next [4];
    logic accept;
    logic wr_now;
    logic [31:0] wdat;
    logic mem_we;
    logic [1:0] mem_waddr;
    logic [1:0] mem_raddr;
    logic [15:0] mem_rdata;
    logic [63:0] mem_q;
    logic do_update;
    logic [1:0] cmd;
    logic [2:0] enabled_cmp;

    // Buffer slot of an index, valid only when is_buf says so
    function automatic logic is_buf(input logic [7:0] idx);
        is_buf = (idx == `TUC_IDX_PERIOD_BUF) || (idx == `TUC_IDX_CMP0_BUF) ||
                 (idx == `TUC_IDX_CMP1_BUF) || (idx == `TUC_IDX_CMP2_BUF);
    endfunction : is_buf

    function automatic logic [1:0] buf_slot(input logic [7:0] idx);
        logic [7:0] rel;
        rel = idx - `TUC_IDX_PERIOD_BUF;
        buf_slot = rel[2:1];
    endfunction : buf_slot

    ////////////////////////////////////////////////////////////////////////////
    // Buffer store

    tuc_buf_mem #(
        .WIDTH(16),
        .DEPTH(4),
        .AW(2)
    ) u_buf (
        .hclk(hclk),
        .hresetn(hresetn),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(wdat[15:0]),
        .raddr(mem_raddr),
        .rdata(mem_rdata),
        .all_q(mem_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: writes take no wait state, reads take two

    assign accept = hsel && htrans[1] && hready;
    assign wr_now = (state_reg == tuc_pkg::TUC_ST_WR);
    assign wdat = hwdata;
    assign mem_we = wr_now && is_buf(idx_reg);
    assign mem_waddr = buf_slot(idx_reg);
    assign mem_raddr = buf_slot(idx_reg);

    always_comb begin
        state_next = state_reg;
        idx_next = idx_reg;
        hrdata_next = hrdata;
        unique case (state_reg)
            tuc_pkg::TUC_ST_RD1: state_next = tuc_pkg::TUC_ST_RD2;
            tuc_pkg::TUC_ST_RD2: begin
                state_next = tuc_pkg::TUC_ST_RDY;
                hrdata_next = '0;
                if (is_buf(idx_reg)) begin
                    hrdata_next[15:0] = mem_rdata;
                end else begin
                    unique case (idx_reg)
                        `TUC_IDX_ENABLE_CTRL: hrdata_next[0] = enable_reg;
                        `TUC_IDX_MODE_CTRL: hrdata_next[6:0] = mode_reg;
                        `TUC_IDX_OUTPUT_VALUE: hrdata_next[2:0] = cov_reg;
                        `TUC_IDX_SPLIT_MODE: hrdata_next[0] = split_reg;
                        // Command bits read zero on both addresses
                        `TUC_IDX_UPD_DIR_CLR,
                        `TUC_IDX_UPD_DIR_SET: hrdata_next[1:0] = {lock_reg, dir_reg};
                        `TUC_IDX_BUF_VALID_CLR,
                        `TUC_IDX_BUF_VALID_SET: hrdata_next[3:0] = bv_reg;
                        `TUC_IDX_ACTIVE_PERIOD: hrdata_next[15:0] = act_reg[0];
                        `TUC_IDX_ACTIVE_CMP0: hrdata_next[15:0] = act_reg[1];
                        `TUC_IDX_ACTIVE_CMP1: hrdata_next[15:0] = act_reg[2];
                        `TUC_IDX_ACTIVE_CMP2: hrdata_next[15:0] = act_reg[3];
                        default: hrdata_next = '0;
                    endcase
                end
            end
            tuc_pkg::TUC_ST_IDLE,
            tuc_pkg::TUC_ST_WR,
            tuc_pkg::TUC_ST_RDY: begin
                state_next = tuc_pkg::TUC_ST_IDLE;
                if (accept) begin
                    idx_next = haddr[9:2];
                    state_next = hwrite ? tuc_pkg::TUC_ST_WR : tuc_pkg::TUC_ST_RD1;
                end
            end
            default: state_next = tuc_pkg::TUC_ST_IDLE;
        endcase
        hreadyout_next = !((state_next == tuc_pkg::TUC_ST_RD1) ||
                           (state_next == tuc_pkg::TUC_ST_RD2));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and status next values

    assign cmd = (wr_now && ((idx_reg == `TUC_IDX_UPD_DIR_CLR) ||
                             (idx_reg == `TUC_IDX_UPD_DIR_SET))) ?
                 wdat[`TUC_POS_CMD_HI:`TUC_POS_CMD_LO] : tuc_pkg::TUC_CMD_NONE;
    assign do_update = (update_event || (cmd == tuc_pkg::TUC_CMD_UPDATE)) && !lock_reg;
    assign enabled_cmp = mode_reg[`TUC_POS_CMPEN_HI:`TUC_POS_CMPEN_LO];

    always_comb begin
        enable_next = enable_reg;
        mode_next = mode_reg;
        cov_next = cov_reg;
        split_next = split_reg;
        lock_next = lock_reg;
        dir_next = dir_reg;
        bv_next = bv_reg;
        for (int i = 0; i < 4; i++) begin
            act_next[i] = act_reg[i];
        end
        // Hardware effects first; software writes below override them
        if (hw_dir_up) begin
            dir_next = 1'b0;
        end
        if (hw_dir_down) begin
            dir_next = 1'b1;
        end
        if (do_update) begin
            for (int i = 0; i < 4; i++) begin
                if (bv_reg[i]) begin
                    act_next[i] = mem_q[i*16 +: 16];
                end
            end
            bv_next = 4'h0;
        end
        if (mode_reg[`TUC_BIT_AUTO_LOCK]) begin
            if (do_update) begin
                lock_next = 1'b1;
            end else if (lock_reg && ((bv_reg[3:1] & enabled_cmp) == enabled_cmp)) begin
                lock_next = 1'b0;
            end
        end
        // A buffer write sets its flag even in an UPDATE cycle
        if (mem_we) begin
            bv_next[mem_waddr] = 1'b1;
        end
        if (wr_now) begin
            unique case (idx_reg)
                `TUC_IDX_ENABLE_CTRL: enable_next = wdat[`TUC_BIT_ENABLE];
                `TUC_IDX_MODE_CTRL: begin
                    mode_next = wdat[6:0];
                    if (wdat[`TUC_BIT_AUTO_LOCK]) begin
                        lock_next = 1'b1;
                    end
                end
                `TUC_IDX_OUTPUT_VALUE: cov_next = wdat[2:0];
                `TUC_IDX_SPLIT_MODE: split_next = wdat[`TUC_BIT_SPLIT];
                `TUC_IDX_UPD_DIR_CLR: begin
                    lock_next = lock_next & ~wdat[`TUC_BIT_LOCK];
                    dir_next = dir_next & ~wdat[`TUC_BIT_DIR];
                end
                `TUC_IDX_UPD_DIR_SET: begin
                    lock_next = lock_next | wdat[`TUC_BIT_LOCK];
                    dir_next = dir_next | wdat[`TUC_BIT_DIR];
                end
                `TUC_IDX_BUF_VALID_CLR: bv_next = bv_next & ~wdat[3:0];
                `TUC_IDX_BUF_VALID_SET: bv_next = bv_next | wdat[3:0];
                default: ;
            endcase
        end
        upd_next = do_update;
        rst_next = (cmd == tuc_pkg::TUC_CMD_RESTART);
        hrst_next = (cmd == tuc_pkg::TUC_CMD_RESET) && !enable_reg;
        // Outputs follow the override bits only while counting is stopped
        forced_next = !enable_next;
        wg_next = enable_next ? wg_reg : cov_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= tuc_pkg::TUC_ST_IDLE;
            idx_reg <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            enable_reg <= 1'b0;
            mode_reg <= 7'h00;
            cov_reg <= 3'h0;
            split_reg <= 1'b0;
            lock_reg <= 1'b0;
            dir_reg <= 1'b0;
            bv_reg <= 4'h0;
            upd_reg <= 1'b0;
            rst_reg <= 1'b0;
            hrst_reg <= 1'b0;
            wg_reg <= 3'h0;
            forced_reg <= 1'b1;
            act_reg[0] <= `TUC_RST_PERIOD;
            for (int i = 1; i < 4; i++) begin
                act_reg[i] <= `TUC_RST_CMP;
            end
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            hrdata <= hrdata_next;
            hreadyout <= hreadyout_next;
            hresp <= 1'b0;
            enable_reg <= enable_next;
            mode_reg <= mode_next;
            cov_reg <= cov_next;
            split_reg <= split_next;
            lock_reg <= lock_next;
            dir_reg <= dir_next;
            bv_reg <= bv_next;
            upd_reg <= upd_next;
            rst_reg <= rst_next;
            hrst_reg <= hrst_next;
            wg_reg <= wg_next;
            forced_reg <= forced_next;
            for (int i = 0; i < 4; i++) begin
                act_reg[i] <= act_next[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs (all straight from flops)

    assign timer_enable = enable_reg;
    assign wgmode = mode_reg[`TUC_POS_WGMODE_HI:0];
    assign compare_enable = enabled_cmp;
    assign split_mode_enable = split_reg;
    assign count_down = dir_reg;
    assign wg_out = wg_reg;
    assign wg_out_forced = forced_reg;
    assign update_pulse = upd_reg;
    assign restart_pulse = rst_reg;
    assign hard_reset_pulse = hrst_reg;
    assign active_period = act_reg[0];
    assign active_compare = {act_reg[3], act_reg[2], act_reg[1]};

endmodule : tuc_regs

/* tb/tuc_regs_assertions.sv */
/*
 * Port checker for tuc_regs: bus handshake, pulses, direction, override.
 * Assumes hready is tied to hreadyout and bound to the single tuc_regs.
 */
`timescale 1ns/1ps
module tuc_regs_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic hw_dir_up,
    input wire logic hw_dir_down,
    input wire logic timer_enable,
    input wire logic count_down,
    input wire logic [2:0] wg_out,
    input wire logic wg_out_forced,
    input wire logic update_pulse,
    input wire logic restart_pulse,
    input wire logic hard_reset_pulse,
    input wire logic [15:0] active_period,
    input wire logic [47:0] active_compare
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic acc = hsel && htrans[1] && hready;
    ////////////////////////////////////////////////////////////
    AST_READ_WAIT: assert property (acc && !hwrite |=>
        !hreadyout ##1 !hreadyout ##1 hreadyout) else $error("read wait not two cycles");
    AST_WRITE_NOWAIT: assert property (acc && hwrite |=> hreadyout)
        else $error("write stalled");
    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("response not okay");
    AST_FORCED_OFF: assert property (timer_enable [*2] |-> !wg_out_forced)
        else $error("override active while enabled");
    AST_FORCED_ON: assert property (!timer_enable [*2] |-> wg_out_forced)
        else $error("override missing while disabled");
    AST_WG_FROZEN: assert property (timer_enable [*3] |-> $stable(wg_out))
        else $error("output value moved while enabled");
    // A copy to the active words must come with its update pulse
    AST_ACTIVE_CAUSE: assert property (
        $changed(active_compare) || $changed(active_period) |-> update_pulse or ##1 update_pulse)
        else $error("active word changed without update");
    AST_RESTART_ONE: assert property (restart_pulse |=> !restart_pulse)
        else $error("restart pulse too long");
    AST_HRST_OFF: assert property (
        hard_reset_pulse |-> !$past(timer_enable) || !$past(timer_enable, 2))
        else $error("hard reset while enabled");
    AST_DIR_DOWN: assert property (
        hw_dir_down && !hw_dir_up && !$past(acc && hwrite) |=> count_down)
        else $error("direction not set down");
    AST_DIR_UP: assert property (
        hw_dir_up && !hw_dir_down && !$past(acc && hwrite) |=> !count_down)
        else $error("direction not set up");
    COV_READ: cover property (acc && !hwrite ##3 hreadyout);
    COV_UPD: cover property (update_pulse);
    COV_HRST: cover property (hard_reset_pulse);
endmodule : tuc_regs_assertions

bind tuc_regs tuc_regs_assertions u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .hw_dir_up, .hw_dir_down, .timer_enable, .count_down,
    .wg_out, .wg_out_forced, .update_pulse, .restart_pulse, .hard_reset_pulse,
    .active_period, .active_compare);

/* tb/tb.sv */
/*
 * Self-checking bench for tuc_regs over AHB-Lite.
 * Assumes hready is the slave's own hreadyout; one master, word access.
 */
`timescale 1ns/1ps
`include "tuc_params.svh"
module tb;
    logic hclk, hresetn, hsel, hwrite, hready, update_event, hw_dir_up, hw_dir_down;
    logic [31:0] haddr, hwdata, hrdata, rd, d, w;
    logic [1:0] htrans;
    logic [2:0] hsize, wgmode, compare_enable, wg_out;
    logic hreadyout, hresp, timer_enable, split_mode_enable, count_down, wg_out_forced;
    logic update_pulse, restart_pulse, hard_reset_pulse;
    logic [15:0] active_period, b0, b1;
    logic [47:0] active_compare;
    logic [3:0] m [2];
    logic [7:0] ci;
    int err_count, checks, n_rst, n_hrst, seed;
    assign hready = hreadyout;
    tuc_regs uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .update_event, .hw_dir_up, .hw_dir_down,
        .timer_enable, .wgmode, .compare_enable, .split_mode_enable, .count_down, .wg_out,
        .wg_out_forced, .update_pulse, .restart_pulse, .hard_reset_pulse,
        .active_period, .active_compare);
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Set/clear pair model: ones act, zeros keep the bit
    function automatic logic [3:0] sc_model(input logic [3:0] cur, input logic set,
        input logic [3:0] bits);
        sc_model = set ? (cur | bits) : (cur & ~bits);
    endfunction : sc_model
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick
    // Address phase held until hready; read data taken at the closing edge
    task automatic bus(input logic wr, input logic [7:0] i, input logic [31:0] wd);
        haddr <= {22'h0, i, 2'h0};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] i, input logic [31:0] wd);
        bus(1'b1, i, wd);
    endtask : wr
    task automatic rchk(input string nm, input logic [7:0] i, input logic [31:0] exp);
        bus(1'b0, i, 32'h0);
        chk(nm, rd, exp);
    endtask : rchk
    // k: 0 update, 1 direction down, 2 direction up
    task automatic strobe(input int k);
        {hw_dir_up, hw_dir_down, update_event} <= 3'h1 << k;
        tick(1);
        {hw_dir_up, hw_dir_down, update_event} <= 3'h0;
        tick(2);
    endtask : strobe
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    always @(posedge hclk) begin
        if (restart_pulse === 1'b1) n_rst++;
        if (hard_reset_pulse === 1'b1) n_hrst++;
    end
    // About 480 cycles are needed; over forty times that means a hang
    initial begin
        tick(20000);
        err_count++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h523FC812;
        {hresetn, hsel, hwrite, update_event, hw_dir_up, hw_dir_down} = 6'h0;
        {haddr, hwdata, htrans, hsize} = {32'h0, 32'h0, 2'h0, 3'h2};
        {err_count, checks, n_rst, n_hrst} = {32'h0, 32'h0, 32'h0, 32'h0};
        tick(12);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        tick(1);
        for (int i = 3; i < 8; i++) rchk("reset value", i[7:0], 32'h0);
        chk("period reset", {16'h0, active_period}, 32'h0000FFFF);
        wr(8'h10, $random(seed));
        rchk("unmapped", 8'h10, 32'h0);
        for (int k = 1; k >= 0; k--) begin
            wr(`TUC_IDX_SPLIT_MODE, k);
            tick(1);
            chk("split", {31'h0, split_mode_enable}, k);
            rchk("split read", `TUC_IDX_SPLIT_MODE, k);
        end
        d = $random(seed);
        wr(`TUC_IDX_OUTPUT_VALUE, {29'h0, d[2:0]});
        tick(2);
        chk("wg_out", {29'h0, wg_out}, {29'h0, d[2:0]});
        wr(`TUC_IDX_ENABLE_CTRL, 32'h1);
        wr(`TUC_IDX_OUTPUT_VALUE, {29'h0, ~d[2:0]});
        tick(2);
        chk("wg_out frozen", {29'h0, wg_out}, {29'h0, d[2:0]});
        chk("forced", {31'h0, wg_out_forced}, 32'h0);
        wr(`TUC_IDX_UPD_DIR_SET, 32'hC);
        tick(3);
        chk("hard reset ignored", n_hrst, 32'h0);
        wr(`TUC_IDX_ENABLE_CTRL, 32'h0);
        wr(`TUC_IDX_UPD_DIR_SET, 32'hC);
        tick(3);
        chk("hard reset", n_hrst, 32'h1);
        chk("wg_out released", {29'h0, wg_out}, {29'h0, ~d[2:0]});
        wr(`TUC_IDX_UPD_DIR_SET, 32'h8);
        tick(3);
        chk("restart", n_rst, 32'h1);
        rchk("command reads zero", `TUC_IDX_UPD_DIR_SET, 32'h0);
        m[0] = 4'h0;
        m[1] = 4'h0;
        // Random set/clear on both pairs; commands kept out of the first pair
        for (int i = 0; i < 32; i++) begin
            d = $random(seed);
            ci = d[9] ? `TUC_IDX_BUF_VALID_CLR : `TUC_IDX_UPD_DIR_CLR;
            w = {24'h0, d[7:4], d[3:2] & {2{d[9]}}, d[1:0]};
            m[d[9]] = sc_model(m[d[9]], d[8], w[3:0]);
            wr(ci + {7'h0, d[8]}, w);
            rchk("clear addr read", ci, {28'h0, m[d[9]]});
            rchk("set addr read", ci + 8'h1, {28'h0, m[d[9]]});
            chk("count_down", {31'h0, count_down}, {31'h0, m[0][0]});
        end
        wr(`TUC_IDX_UPD_DIR_CLR, 32'h3);
        wr(`TUC_IDX_BUF_VALID_CLR, 32'hF);
        strobe(1);
        chk("hw down", {31'h0, count_down}, 32'h1);
        rchk("hw down read", `TUC_IDX_UPD_DIR_CLR, 32'h1);
        strobe(2);
        chk("hw up", {31'h0, count_down}, 32'h0);
        // Hardware down pulse lands in the very cycle of the software clear
        fork
            wr(`TUC_IDX_UPD_DIR_CLR, 32'h1);
            begin
                tick(1);
                hw_dir_down <= 1'b1;
                tick(1);
                hw_dir_down <= 1'b0;
            end
        join
        tick(1);
        chk("sw beats hw", {31'h0, count_down}, 32'h0);
        d = $random(seed);
        b0 = d[15:0] | 16'h0001;
        b1 = d[31:16] | 16'h0001;
        wr(`TUC_IDX_CMP0_BUF, {16'h0, b0});
        rchk("cmp0 valid", `TUC_IDX_BUF_VALID_SET, 32'h2);
        wr(`TUC_IDX_PERIOD_BUF, {16'h0, b1});
        rchk("period valid", `TUC_IDX_BUF_VALID_SET, 32'h3);
        wr(`TUC_IDX_UPD_DIR_SET, 32'h2);
        strobe(0);
        chk("locked copy", {16'h0, active_compare[15:0]}, 32'h0);
        chk("locked period", {16'h0, active_period}, 32'h0000FFFF);
        wr(`TUC_IDX_UPD_DIR_CLR, 32'h2);
        strobe(0);
        chk("cmp0 copy", {16'h0, active_compare[15:0]}, {16'h0, b0});
        chk("period copy", {16'h0, active_period}, {16'h0, b1});
        rchk("valid cleared", `TUC_IDX_BUF_VALID_CLR, 32'h0);
        wr(`TUC_IDX_CMP1_BUF, {16'h0, b0});
        wr(`TUC_IDX_UPD_DIR_SET, 32'h4);
        tick(3);
        chk("forced update", {16'h0, active_compare[31:16]}, {16'h0, b0});
        rchk("valid after cmd", `TUC_IDX_BUF_VALID_SET, 32'h0);
        // Auto-lock with only channel 0 enabled: lock holds until its buffer is valid
        d = $random(seed);
        wr(`TUC_IDX_MODE_CTRL, {25'h0, 3'h1, 1'b1, d[2:0]});
        tick(1);
        chk("wgmode", {29'h0, wgmode}, {29'h0, d[2:0]});
        chk("compare_enable", {29'h0, compare_enable}, 32'h1);
        rchk("auto lock set", `TUC_IDX_UPD_DIR_CLR, 32'h2);
        strobe(0);
        chk("auto lock holds", {16'h0, active_compare[15:0]}, {16'h0, b0});
        wr(`TUC_IDX_CMP0_BUF, {16'h0, ~b0});
        rchk("auto lock released", `TUC_IDX_UPD_DIR_CLR, 32'h0);
        strobe(0);
        chk("auto copy", {16'h0, active_compare[15:0]}, {16'h0, ~b0});
        rchk("auto lock again", `TUC_IDX_UPD_DIR_CLR, 32'h2);
        give_verdict();
    end
endmodule : tb
